//--- rtl/vcarb_regs.sv
// Channel 0 port arbitration capability and control registers behind an AXI4-Lite slave.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none
module vcarb_regs
  import vcarb_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [VCARB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [VCARB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic table_entry_written,
  input wire logic arb_load_done,
  output logic arb_load_start,
  output logic [7:0] traffic_class_map,
  output logic [2:0] port_arb_select
);

  // Capability word is constant per port flavour; every field of it, low byte included, is built here.
  localparam logic [7:0] ARB_TABLE_OFFSET = IS_UPSTREAM ? ARB_TABLE_OFFSET_UP
                                                         : ARB_TABLE_OFFSET_DOWN;
  localparam logic [7:0] ARB_CAP = IS_UPSTREAM ? ARB_CAP_UP : ARB_CAP_DOWN;

  logic [31:0] cap_word;
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[CAP_ARBCAP_LSB +: 8] = ARB_CAP;
    cap_word[CAP_ADV_PKT_SW_BIT] = 1'b0;
    cap_word[CAP_REJ_SNOOP_BIT] = 1'b0;
    cap_word[CAP_MAX_TIME_SLOTS_MSB:CAP_MAX_TIME_SLOTS_LSB] = MAX_TIME_SLOTS_VAL;
    cap_word[CAP_TBLOFF_LSB +: 8] = ARB_TABLE_OFFSET;
  end

  // Write channel holding registers: address and data may arrive in either order.
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [VCARB_ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic [7:0] tcmap_ff, nxt_tcmap;
  logic [2:0] arbsel_ff, nxt_arbsel;
  logic tbl_status_ff, nxt_tbl_status;
  logic load_start_ff, nxt_load_start;
  vcarb_load_e load_state_ff, nxt_load_state;
  logic do_write;
  logic [VCARB_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic sel_uses_table;
  logic load_req;
  logic [7:0] tcmap_wr;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Only fixed round robin needs no table; every other advertised scheme reads it.
  assign sel_uses_table = (arbsel_ff != ARB_SEL_RESET);

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held = w_held_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_tcmap = tcmap_ff;
    nxt_arbsel = arbsel_ff;
    load_req = 1'b0;
    wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
    wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    do_write = (aw_held_ff || (s_axi_awvalid && s_axi_awready)) &&
               (w_held_ff || (s_axi_wvalid && s_axi_wready)) && !bvalid_ff;
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      case (wr_addr[VCARB_ADDR_W-1:2])
        VCARB_CTL_ADDR[VCARB_ADDR_W-1:2]: begin
          if (wr_strb[0]) begin
            nxt_tcmap = tcmap_wr;
          end
          if (wr_strb[2]) begin
            nxt_arbsel = wr_data[CTL_SEL_LSB +: 3];
            // A one starts a load only upstream with a non-round-robin select already held; a zero is not acted on.
            load_req = IS_UPSTREAM && wr_data[CTL_LOAD_BIT] && sel_uses_table;
          end
        end
        VCARB_CAP_ADDR[VCARB_ADDR_W-1:2], VCARB_STS_ADDR[VCARB_ADDR_W-1:2]: begin
          nxt_bresp = RESP_OKAY;
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      tcmap_ff <= TCMAP_RESET;
      arbsel_ff <= ARB_SEL_RESET;
    end else begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
      w_held_ff <= nxt_w_held;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      tcmap_ff <= nxt_tcmap;
      arbsel_ff <= nxt_arbsel;
    end
  end

  // Per-bit map update value. Bit 0 has no write path, so traffic class 0 can never be
  // unmapped by software and always stays on this channel.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_tcmap
      if (TCMAP_WR_MASK[gi]) begin : g_rw
        assign tcmap_wr[gi] = wr_data[CTL_TCMAP_LSB + gi];
      end else begin : g_ro
        assign tcmap_wr[gi] = TCMAP_RESET[gi];
      end
    end
  endgenerate

  // Table status and load sequencing. The load waits for the arbiter's done pulse, so
  // software sees status fall only once the new table is really latched.
  always_comb begin
    nxt_tbl_status = tbl_status_ff;
    nxt_load_start = 1'b0;
    nxt_load_state = load_state_ff;
    case (load_state_ff)
      VCARB_IDLE: begin
        nxt_load_state = VCARB_IDLE;
      end
      VCARB_LOAD: begin
        if (arb_load_done) begin
          nxt_load_state = VCARB_IDLE;
          nxt_tbl_status = 1'b0;
        end
      end
      default: begin
        nxt_load_state = VCARB_IDLE;
      end
    endcase
    // A table write in the same cycle as the done pulse leaves the status set.
    if (IS_UPSTREAM && table_entry_written) begin
      nxt_tbl_status = 1'b1;
    end
    if (load_req) begin
      nxt_load_start = 1'b1;
      nxt_load_state = VCARB_LOAD;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_status_ff <= 1'b0;
      load_start_ff <= 1'b0;
      load_state_ff <= VCARB_IDLE;
    end else begin
      tbl_status_ff <= nxt_tbl_status;
      load_start_ff <= nxt_load_start;
      load_state_ff <= nxt_load_state;
    end
  end

  assign arb_load_start = load_start_ff;
  assign traffic_class_map = tcmap_ff;
  assign port_arb_select = arbsel_ff;

  // Read channel: one outstanding read, answered one cycle after the address is taken.
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] ctl_word;

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[CTL_TCMAP_LSB +: 8] = tcmap_ff;
    ctl_word[CTL_LOAD_BIT] = 1'b0;
    ctl_word[CTL_SEL_LSB +: 3] = arbsel_ff;
    ctl_word[CTL_CHID_LSB +: 3] = CHANNEL_ID_VAL;
    ctl_word[CTL_EN_BIT] = CHANNEL_EN_VAL;
  end

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (s_axi_araddr[VCARB_ADDR_W-1:2])
        VCARB_CAP_ADDR[VCARB_ADDR_W-1:2]: nxt_rdata = cap_word;
        VCARB_CTL_ADDR[VCARB_ADDR_W-1:2]: nxt_rdata = ctl_word;
        VCARB_STS_ADDR[VCARB_ADDR_W-1:2]: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rdata[STS_TBL_BIT] = tbl_status_ff;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

endmodule
`default_nettype wire

//--- rtl/vcarb_pkg.sv
// Package with register map, field layout and reset values for the channel 0 arbitration registers.
`default_nettype none
package vcarb_pkg;
  localparam logic [11:0] VCARB_CAP_ADDR = 12'h210;
  localparam logic [11:0] VCARB_CTL_ADDR = 12'h214;
  localparam logic [11:0] VCARB_STS_ADDR = 12'h218;
  localparam logic [11:0] VCARB_TBLW_ADDR = 12'h21C;
  localparam int VCARB_ADDR_W = 12;
  localparam int CAP_ADV_PKT_SW_BIT = 14;
  localparam int CAP_REJ_SNOOP_BIT = 15;
  localparam int CAP_MAX_TIME_SLOTS_LSB = 16;
  localparam int CAP_MAX_TIME_SLOTS_MSB = 22;
  localparam int CAP_TBLOFF_LSB = 24;
  localparam int CAP_ARBCAP_LSB = 0;
  localparam logic [7:0] ARB_TABLE_OFFSET_UP = 8'h02;
  localparam logic [7:0] ARB_TABLE_OFFSET_DOWN = 8'h00;
  localparam logic [7:0] ARB_CAP_UP = 8'h03;
  localparam logic [7:0] ARB_CAP_DOWN = 8'h01;
  localparam logic [6:0] MAX_TIME_SLOTS_VAL = 7'h00;
  localparam int CTL_TCMAP_LSB = 0;
  localparam int CTL_LOAD_BIT = 16;
  localparam int CTL_SEL_LSB = 17;
  localparam int CTL_CHID_LSB = 24;
  localparam int CTL_EN_BIT = 31;
  localparam int STS_TBL_BIT = 16;
  localparam logic [7:0] TCMAP_RESET = 8'hFF;
  localparam logic [7:0] TCMAP_WR_MASK = 8'hFE;
  localparam logic [2:0] ARB_SEL_RESET = 3'h0;
  localparam logic [2:0] CHANNEL_ID_VAL = 3'h0;
  localparam logic CHANNEL_EN_VAL = 1'b1;
  localparam int LOAD_CYCLES = 4;
  localparam logic [2:0] LOAD_CNT_MAX = 3'(LOAD_CYCLES - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    VCARB_IDLE = 2'b00,
    VCARB_LOAD = 2'b01
  } vcarb_load_e;
endpackage
`default_nettype wire

//--- verification/vcarb_regs_assertions.sv
// Checker for the channel 0 arbitration register block.
`default_nettype none
module vcarb_regs_chk
  import vcarb_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [VCARB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic arb_load_start,
  input wire logic [7:0] traffic_class_map,
  input wire logic [2:0] port_arb_select
);
  logic [VCARB_ADDR_W-1:0] ra_ff;
  logic [VCARB_ADDR_W-1:0] nxt_ra;
  logic rd_cap;
  logic rd_ctl;
  always_comb begin
    nxt_ra = ra_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_ra = s_axi_araddr;
    end
  end
  always_ff @(posedge aclk) begin
    ra_ff <= nxt_ra;
  end
  assign rd_cap = s_axi_rvalid && ra_ff == VCARB_CAP_ADDR;
  assign rd_ctl = s_axi_rvalid && ra_ff == VCARB_CTL_ADDR;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_one_pulse;
    arb_load_start ##1 !arb_load_start;
  endsequence
  a_map_bit0: assert property (traffic_class_map[0])
    else $error("map bit 0 low");
  a_reset_vals: assert property ($rose(aresetn) |-> traffic_class_map == 8'hFF
    && port_arb_select == 3'h0) else $error("bad reset values");
  a_cap_upper: assert property (rd_cap |-> s_axi_rdata[31:8] ==
    {(IS_UPSTREAM ? 8'h02 : 8'h00), 16'h0000}) else $error("cap upper bits wrong");
  a_cap_scheme: assert property (rd_cap |-> s_axi_rdata[7:0] ==
    (IS_UPSTREAM ? 8'h03 : 8'h01)) else $error("cap schemes wrong");
  a_ctl_fixed: assert property (rd_ctl |-> s_axi_rdata[31:20] == 12'h800
    && s_axi_rdata[16:8] == 9'h000) else $error("ctl fixed bits wrong");
  a_load_pulse: assert property ($rose(arb_load_start) |-> s_one_pulse)
    else $error("load start not one cycle");
  a_load_cause: assert property (arb_load_start |-> IS_UPSTREAM && s_axi_bvalid
    && $past(port_arb_select) != 3'h0) else $error("load start without cause");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind vcarb_regs vcarb_regs_chk #(.IS_UPSTREAM(IS_UPSTREAM)) u_chk (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_bvalid, .arb_load_start, .traffic_class_map, .port_arb_select);
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the channel 0 arbitration register block.
`default_nettype none
module tb_top
  import vcarb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, arvalid, tew, ald;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, load_start;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] tc_map;
  wire [2:0] arb_sel;
  int failures, n_compared, loads, m_map, m_sel, m_sts;
  vcarb_regs #(.IS_UPSTREAM(1'b1)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .table_entry_written(tew), .arb_load_done(ald), .arb_load_start(load_start),
    .traffic_class_map(tc_map), .port_arb_select(arb_sel));
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (load_start === 1'b1) loads++;
  end
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Ready is sampled at the edge, so each channel drops valid only once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata; r = rresp;
  endtask
  function automatic logic [31:0] ctl_exp();
    return {1'b1, 11'h000, 3'(m_sel), 9'h000, 8'(m_map)};
  endfunction
  task automatic rd_all();
    rd(VCARB_CAP_ADDR); chk(d, 32'h0200_0003, "cap");
    rd(VCARB_CTL_ADDR); chk(d, ctl_exp(), "ctl");
    rd(VCARB_STS_ADDR); chk(d, m_sts ? 32'h0001_0000 : 32'h0, "status");
  endtask
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    tew = 1'b0; ald = 1'b0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0;
    m_map = 255; m_sel = 0; m_sts = 0;
    void'($urandom(78144));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_all();
    // Random words also hit reserved and read-only bits, which must not stick.
    for (int i = 0; i < 8; i++) begin
      d = $urandom & 32'hFFFE_FFFF;
      d[19:17] = 3'(i % 2);
      wr(VCARB_CTL_ADDR, d); chk(r, RESP_OKAY, "ctl resp");
      m_map = {d[7:1], 1'b1}; m_sel = i % 2;
      wr(VCARB_CAP_ADDR, $urandom); chk(r, RESP_OKAY, "cap resp");
      rd_all();
    end
    tew <= 1'b1;
    @(posedge aclk);
    tew <= 1'b0; m_sts = 1;
    rd_all();
    m_sel = 1;
    wr(VCARB_CTL_ADDR, ctl_exp() | 32'h0001_0000);
    rd_all(); chk(loads, 1, "load pulse");
    ald <= 1'b1;
    @(posedge aclk);
    ald <= 1'b0; m_sts = 0;
    rd_all();
    m_sel = 0;
    wr(VCARB_CTL_ADDR, ctl_exp());
    wr(VCARB_CTL_ADDR, ctl_exp() | 32'h0001_0000);
    rd_all(); chk(loads, 1, "load with round robin");
    wr(12'h300, $urandom); chk(r, RESP_SLVERR, "unmapped write");
    rd(12'h300); chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    chk(d, 32'h0, "unmapped read data");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
